// >>> common/anpr_consts.svh
// Offsets, field positions, reset values and masks for the page register bank.
// Assumes inclusion by bare name from a file that uses these macros.
`ifndef ANPR_CONSTS_SVH
`define ANPR_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ANPR_IDX_PARTNER 5'h05
`define ANPR_IDX_EXPANSION 5'h06
`define ANPR_IDX_NPTX 5'h07
`define ANPR_IDX_PORTCFG 5'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ANPR_PB_RESERVED 12
`define ANPR_EX_BASE_PAGE 5
`define ANPR_EX_PD_FAULT 4
`define ANPR_EX_PARTNER_NP 3
`define ANPR_EX_LOCAL_NP 2
`define ANPR_EX_PAGE_RCVD 1
`define ANPR_EX_PARTNER_AN 0
`define ANPR_NP_MORE 15
`define ANPR_NP_RESERVED 14
`define ANPR_NP_FORMATTED 13
`define ANPR_NP_COMPLY 12
`define ANPR_NP_TOGGLE 11
`define ANPR_CFG_ALT_PAGING 1

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define ANPR_PARTNER_RESET 16'h0000
`define ANPR_PARTNER_MASK 16'hefff
`define ANPR_NPTX_RESET 16'h2001
`define ANPR_NPTX_WMASK 16'hbfff
`define ANPR_LOCAL_NP_ABLE 1'b1
`define ANPR_ALT_PAGING_RESET 1'b0
`define ANPR_RESP_OKAY 2'h0
`define ANPR_RESP_SLVERR 2'h2

`endif

// >>> common/anpr_pkg.sv
// Types shared by the page register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package anpr_pkg;

   typedef logic [15:0] anpr_word_t;

   typedef enum logic [2:0]
   {
      ANPR_SEL_NONE = 3'b000,
      ANPR_SEL_PARTNER = 3'b001,
      ANPR_SEL_EXPANSION = 3'b010,
      ANPR_SEL_NPTX = 3'b011,
      ANPR_SEL_PORTCFG = 3'b100
   } anpr_sel_e;

   typedef enum logic
   {
      ANPR_WR_COLLECT = 1'b0,
      ANPR_WR_RESPOND = 1'b1
   } anpr_wr_state_e;

endpackage : anpr_pkg

// >>> core/anpr_regs.sv
// Auto-negotiation page register bank with an AXI4-Lite slave port.
// Assumes the negotiation engine runs on aclk and drives its events as
// one-cycle pulses and its status as levels.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "anpr_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module anpr_regs
   import anpr_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic page_rx_valid,
   input wire logic page_rx_is_base,
   input wire logic [15:0] page_rx_word,
   input wire logic base_page_event,
   input wire logic parallel_fault_event,
   input wire logic partner_np_able,
   input wire logic partner_an_able,
   input wire logic partner_page_pending,
   input wire logic transmit_disable,
   output logic [15:0] next_page_word,
   output logic alternate_paging_enable
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   generate
      if (ADDR_W < 7)
      begin : g_bad_addr
         $error("ADDR_W must be at least 7 to reach every register");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic anpr_sel_e anpr_decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] upper;
      logic [4:0] idx;
      anpr_sel_e sel;
      upper = addr >> 7;
      idx = addr[6:2];
      sel = ANPR_SEL_NONE;
      if (upper == '0 && addr[1:0] == 2'h0)
      begin
         unique case (idx)
            `ANPR_IDX_PARTNER: sel = ANPR_SEL_PARTNER;
            `ANPR_IDX_EXPANSION: sel = ANPR_SEL_EXPANSION;
            `ANPR_IDX_NPTX: sel = ANPR_SEL_NPTX;
            `ANPR_IDX_PORTCFG: sel = ANPR_SEL_PORTCFG;
            default: sel = ANPR_SEL_NONE;
         endcase
      end
      return sel;
   endfunction : anpr_decode

   // Byte-lane merge for a 16-bit register
   function automatic anpr_word_t anpr_merge(input anpr_word_t old_val,
                                             input logic [31:0] data,
                                             input logic [3:0] strb,
                                             input anpr_word_t wmask);
      anpr_word_t lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      return (old_val & ~lanes) | (data[15:0] & lanes);
   endfunction : anpr_merge

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   anpr_word_t partner_base_page_ability_reg;
   anpr_word_t next_page_transmit_word_reg;
   logic alternate_paging_enable_reg;
   logic base_page_flag_reg;
   logic pd_fault_flag_reg;
   logic page_rcvd_flag_reg;
   anpr_word_t expansion_view;

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   anpr_wr_state_e wr_state_reg;
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic aw_hs;
   logic w_hs;
   logic wr_commit;
   logic b_hs;
   anpr_sel_e wr_sel;

   assign aw_hs = s_axi_awvalid & awready_reg;
   assign w_hs = s_axi_wvalid & wready_reg;
   assign wr_commit = (wr_state_reg == ANPR_WR_COLLECT) & aw_held_reg & w_held_reg;
   assign b_hs = bvalid_reg & s_axi_bready;
   assign wr_sel = anpr_decode(awaddr_reg);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_reg <= 1'b0;
         awready_reg <= 1'b0;
         awaddr_reg <= '0;
      end
      else if (aw_hs)
      begin
         aw_held_reg <= 1'b1;
         awready_reg <= 1'b0;
         awaddr_reg <= s_axi_awaddr;
      end
      else if (b_hs || (!aw_held_reg && !awready_reg))
      begin
         aw_held_reg <= 1'b0;
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_reg <= 1'b0;
         wready_reg <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end
      else if (w_hs)
      begin
         w_held_reg <= 1'b1;
         wready_reg <= 1'b0;
         wdata_reg <= s_axi_wdata;
         wstrb_reg <= s_axi_wstrb;
      end
      else if (b_hs || (!w_held_reg && !wready_reg))
      begin
         w_held_reg <= 1'b0;
         wready_reg <= 1'b1;
      end
   end

   // Response only once both halves are in; address and data may come in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_state_reg <= ANPR_WR_COLLECT;
         bvalid_reg <= 1'b0;
         bresp_reg <= `ANPR_RESP_OKAY;
      end
      else
      begin
         unique case (wr_state_reg)
            ANPR_WR_COLLECT:
            begin
               if (wr_commit)
               begin
                  wr_state_reg <= ANPR_WR_RESPOND;
                  bvalid_reg <= 1'b1;
                  bresp_reg <= (wr_sel == ANPR_SEL_NONE) ? `ANPR_RESP_SLVERR
                                                         : `ANPR_RESP_OKAY;
               end
            end
            ANPR_WR_RESPOND:
            begin
               if (b_hs)
               begin
                  wr_state_reg <= ANPR_WR_COLLECT;
                  bvalid_reg <= 1'b0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Writable registers
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         next_page_transmit_word_reg <= `ANPR_NPTX_RESET;
      end
      else if (wr_commit && wr_sel == ANPR_SEL_NPTX)
      begin
         // Bit 14 masked out so it always reads zero
         next_page_transmit_word_reg <= anpr_merge(next_page_transmit_word_reg, wdata_reg,
                                                   wstrb_reg, `ANPR_NPTX_WMASK);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         alternate_paging_enable_reg <= `ANPR_ALT_PAGING_RESET;
      end
      else if (wr_commit && wr_sel == ANPR_SEL_PORTCFG && wstrb_reg[0])
      begin
         alternate_paging_enable_reg <= wdata_reg[`ANPR_CFG_ALT_PAGING];
      end
   end

   assign next_page_word = next_page_transmit_word_reg;
   assign alternate_paging_enable = alternate_paging_enable_reg;

   // ----------------------------------------------------------------
   // Partner base page (software can never write it)
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         partner_base_page_ability_reg <= `ANPR_PARTNER_RESET;
      end
      else if (page_rx_valid && page_rx_is_base)
      begin
         // Whole code word kept; reserved bit 12 dropped
         partner_base_page_ability_reg <= page_rx_word & `ANPR_PARTNER_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic ar_hs;
   logic exp_read;
   anpr_sel_e rd_sel;
   anpr_word_t rd_word;

   assign ar_hs = s_axi_arvalid & arready_reg;
   assign rd_sel = anpr_decode(s_axi_araddr);
   assign exp_read = ar_hs & (rd_sel == ANPR_SEL_EXPANSION);

   assign expansion_view = {10'h000,
                            base_page_flag_reg,
                            pd_fault_flag_reg,
                            partner_np_able,
                            `ANPR_LOCAL_NP_ABLE,
                            page_rcvd_flag_reg,
                            partner_an_able};

   always_comb
   begin
      rd_word = 16'h0000;
      unique case (rd_sel)
         ANPR_SEL_PARTNER: rd_word = partner_base_page_ability_reg;
         ANPR_SEL_EXPANSION: rd_word = expansion_view;
         ANPR_SEL_NPTX: rd_word = next_page_transmit_word_reg;
         ANPR_SEL_PORTCFG: rd_word = {14'h0000, alternate_paging_enable_reg, 1'b0};
         ANPR_SEL_NONE: rd_word = 16'h0000;
      endcase
   end

   // One read in flight; the address is sampled at the handshake edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `ANPR_RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= {16'h0000, rd_word};
         rresp_reg <= (rd_sel == ANPR_SEL_NONE) ? `ANPR_RESP_SLVERR : `ANPR_RESP_OKAY;
      end
      else if (rvalid_reg && s_axi_rready)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
      else if (!rvalid_reg)
      begin
         arready_reg <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Latching status flags (a set in the clearing cycle wins)
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         base_page_flag_reg <= 1'b0;
      end
      else if (base_page_event && alternate_paging_enable_reg)
      begin
         base_page_flag_reg <= 1'b1;
      end
      else if (exp_read)
      begin
         base_page_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pd_fault_flag_reg <= 1'b0;
      end
      else if (parallel_fault_event)
      begin
         pd_fault_flag_reg <= 1'b1;
      end
      else if (exp_read)
      begin
         pd_fault_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         page_rcvd_flag_reg <= 1'b0;
      end
      else if (page_rx_valid)
      begin
         page_rcvd_flag_reg <= 1'b1;
      end
      else if (exp_read)
      begin
         page_rcvd_flag_reg <= 1'b0;
      end
      else if (alternate_paging_enable_reg && (!partner_page_pending || transmit_disable))
      begin
         page_rcvd_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_partner_load: assert property (page_rx_valid && page_rx_is_base |=>
         partner_base_page_ability_reg == ($past(page_rx_word) & `ANPR_PARTNER_MASK))
      else $error("Partner word not loaded from received base page");

   a_partner_reserved: assert property (!partner_base_page_ability_reg[`ANPR_PB_RESERVED])
      else $error("Partner reserved bit not zero");

   a_partner_ro: assert property (!(page_rx_valid && page_rx_is_base) |=>
         $stable(partner_base_page_ability_reg))
      else $error("Partner register changed without a base page");

   a_page_set: assert property (page_rx_valid |=> page_rcvd_flag_reg[*2] or
         (page_rcvd_flag_reg ##1 !page_rcvd_flag_reg))
      else $error("Page received flag not set");

   a_read_clear: assert property (exp_read && !page_rx_valid |=>
         !page_rcvd_flag_reg && s_axi_rdata[`ANPR_EX_PAGE_RCVD] == $past(page_rcvd_flag_reg))
      else $error("Expansion read did not clear page received");

   a_alt_clear: assert property (alternate_paging_enable_reg && transmit_disable &&
         !page_rx_valid |=> !page_rcvd_flag_reg)
      else $error("Alternate clearing condition ignored");

   a_base_gate: assert property (!alternate_paging_enable_reg && !base_page_flag_reg |=>
         !base_page_flag_reg)
      else $error("Base page flag set while alternate paging off");

   a_fault_hold: assert property (pd_fault_flag_reg && !exp_read |=> pd_fault_flag_reg)
      else $error("Parallel fault flag dropped without a read");

   a_fault_set: assert property (parallel_fault_event |=> pd_fault_flag_reg)
      else $error("Parallel fault flag not set");

   a_nptx_write: assert property (wr_commit && wr_sel == ANPR_SEL_NPTX &&
         wstrb_reg[1:0] == 2'h3 |=> s_axi_bvalid && next_page_transmit_word_reg ==
         (anpr_word_t'($past(wdata_reg)) & `ANPR_NPTX_WMASK))
      else $error("Next page word not written as given");

   a_nptx_reserved: assert property (!next_page_transmit_word_reg[`ANPR_NP_RESERVED])
      else $error("Next page reserved bit not zero");

   a_local_np: assert property (rvalid_reg && $past(exp_read) |->
         s_axi_rdata[`ANPR_EX_LOCAL_NP] && s_axi_rdata[15:6] == 10'h000)
      else $error("Expansion read shows wrong constant bits");

   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
         s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped before bready");

endmodule : anpr_regs

`default_nettype wire

// >>> tb/anpr_mgmt_model.sv
// Management controller model: an AXI4-Lite master, one access at a time.
// Assumes the slave answers on aclk; only the bench watchdog ends a hang.
`timescale 1ns/1ns
`default_nettype none

module anpr_mgmt_model
(
   input wire logic aclk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial
   begin
      awaddr = 8'hff;
      awvalid = 1'b0;
      wdata = 32'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'hff;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // Software sets the writable words and the paging mode
   task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_left;
      logic w_left;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_left = 1'b1;
      w_left = 1'b1;
      while (aw_left || w_left)
      begin
         @(posedge aclk);
         if (aw_left && awready === 1'b1)
         begin
            aw_left = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_left && wready === 1'b1)
         begin
            w_left = 1'b0;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      while (bvalid !== 1'b1)
         @(posedge aclk);
      r = bresp;
      bready <= 1'b0;
   endtask : write

   task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_left;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      ar_left = 1'b1;
      while (ar_left || rvalid !== 1'b1)
      begin
         @(posedge aclk);
         if (ar_left && arready === 1'b1)
         begin
            ar_left = 1'b0;
            arvalid <= 1'b0;
         end
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : read
endmodule : anpr_mgmt_model

`default_nettype wire

// >>> tb/tb.sv
// Bench for the page register bank: reset values, partner page capture,
// latching flags, alternate paging and the next page transmit word.
// Assumes anpr_regs and anpr_mgmt_model are compiled before it.
`include "anpr_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module tb;
   localparam logic [7:0] ad_par = {1'b0, `ANPR_IDX_PARTNER, 2'b00};
   localparam logic [7:0] ad_exp = {1'b0, `ANPR_IDX_EXPANSION, 2'b00};
   localparam logic [7:0] ad_np = {1'b0, `ANPR_IDX_NPTX, 2'b00};
   localparam logic [7:0] ad_cfg = {1'b0, `ANPR_IDX_PORTCFG, 2'b00};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic page_rx_valid = 1'b0;
   logic page_rx_is_base = 1'b0;
   logic [15:0] page_rx_word = 16'h0;
   logic base_page_event = 1'b0;
   logic parallel_fault_event = 1'b0;
   logic partner_np_able = 1'b0;
   logic partner_an_able = 1'b0;
   logic partner_page_pending = 1'b1;
   logic transmit_disable = 1'b0;
   logic [3:0] wstrb = 4'hf;
   logic [15:0] next_page_word;
   logic alternate_paging_enable;
   int n_mismatch = 0;
   int checks_done = 0;

   always #5 aclk = ~aclk;

   anpr_regs dut_u
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .page_rx_valid(page_rx_valid),
      .page_rx_is_base(page_rx_is_base), .page_rx_word(page_rx_word),
      .base_page_event(base_page_event), .parallel_fault_event(parallel_fault_event),
      .partner_np_able(partner_np_able), .partner_an_able(partner_an_able),
      .partner_page_pending(partner_page_pending), .transmit_disable(transmit_disable),
      .next_page_word(next_page_word), .alternate_paging_enable(alternate_paging_enable)
   );

   anpr_mgmt_model mgmt_u
   (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic final_report();
      $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      mgmt_u.write(a, d, r);
      check("bresp", {30'h0, r}, {30'h0, `ANPR_RESP_OKAY});
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] d;
      logic [1:0] r;
      mgmt_u.read(a, d, r);
      check("rdata", d, {16'h0000, e});
      check("rresp", {30'h0, r}, {30'h0, `ANPR_RESP_OKAY});
   endtask : rd_chk

   task automatic page(input logic base, input logic [15:0] w);
      @(posedge aclk);
      page_rx_valid <= 1'b1;
      page_rx_is_base <= base;
      page_rx_word <= w;
      @(posedge aclk);
      page_rx_valid <= 1'b0;
      page_rx_word <= ~w;
   endtask : page

   // One-cycle pulses: k[0] base page, k[1] parallel fault
   task automatic ev(input logic [1:0] k);
      @(posedge aclk);
      base_page_event <= k[0];
      parallel_fault_event <= k[1];
      @(posedge aclk);
      base_page_event <= 1'b0;
      parallel_fault_event <= 1'b0;
   endtask : ev

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      rd_chk(ad_par, 16'h0000);
      rd_chk(ad_exp, 16'h0004);
      rd_chk(ad_np, 16'h2001);
      rd_chk(ad_cfg, 16'h0000);
      check("alt enable", {31'h0, alternate_paging_enable}, 32'h0);
      check("next page word", {16'h0, next_page_word}, 32'h2001);
      mgmt_u.read(8'h20, d, r);
      check("unmapped rdata", d, 32'h0);
      check("unmapped rresp", {30'h0, r}, {30'h0, `ANPR_RESP_SLVERR});
      mgmt_u.write(8'h20, 32'hffffffff, r);
      check("unmapped bresp", {30'h0, r}, {30'h0, `ANPR_RESP_SLVERR});
   endtask : t_reset

   // Alternate mode off: a low pending level must not clear the flag
   task automatic t_pages();
      logic [15:0] pw [5] = '{16'h8001, 16'h4002, 16'h3c00, 16'h03e0, 16'hffff};
      partner_page_pending <= 1'b0;
      foreach (pw[i])
      begin
         page(1'b1, pw[i]);
         rd_chk(ad_par, pw[i] & 16'hefff);
      end
      rd_chk(ad_exp, 16'h0006);
      rd_chk(ad_exp, 16'h0004);
      page(1'b0, 16'h1234);
      rd_chk(ad_par, 16'hefff);
      rd_chk(ad_exp, 16'h0006);
      wr(ad_par, 32'h0);
      rd_chk(ad_par, 16'hefff);
      wr(ad_exp, 32'hffffffff);
      rd_chk(ad_exp, 16'h0004);
      partner_page_pending <= 1'b1;
   endtask : t_pages

   task automatic t_flags();
      partner_np_able <= 1'b1;
      partner_an_able <= 1'b1;
      ev(2'b01);
      ev(2'b10);
      repeat (3) @(posedge aclk);
      rd_chk(ad_exp, 16'h001d);
      rd_chk(ad_exp, 16'h000d);
      partner_np_able <= 1'b0;
      rd_chk(ad_exp, 16'h0005);
   endtask : t_flags

   task automatic t_alt();
      wr(ad_cfg, 32'hffffffff);
      rd_chk(ad_cfg, 16'h0002);
      check("alt enable", {31'h0, alternate_paging_enable}, 32'h1);
      ev(2'b01);
      rd_chk(ad_exp, 16'h0025);
      page(1'b0, 16'h0000);
      rd_chk(ad_exp, 16'h0007);
      page(1'b0, 16'h0000);
      @(posedge aclk);
      transmit_disable <= 1'b1;
      @(posedge aclk);
      transmit_disable <= 1'b0;
      rd_chk(ad_exp, 16'h0005);
      page(1'b0, 16'h0000);
      @(posedge aclk);
      partner_page_pending <= 1'b0;
      @(posedge aclk);
      partner_page_pending <= 1'b1;
      rd_chk(ad_exp, 16'h0005);
      wr(ad_cfg, 32'h0);
      rd_chk(ad_cfg, 16'h0000);
   endtask : t_alt

   task automatic t_nptx();
      logic [31:0] wd [3] = '{32'hffffffff, 32'h00000000, 32'h00005a5a};
      logic [15:0] ex [3] = '{16'hbfff, 16'h0000, 16'h1a5a};
      foreach (wd[i])
      begin
         wr(ad_np, wd[i]);
         rd_chk(ad_np, ex[i]);
         check("next page word", {16'h0, next_page_word}, {16'h0, ex[i]});
      end
      // Low byte lane only: the upper byte must keep its old value
      wstrb <= 4'h1;
      wr(ad_np, 32'h0000ffff);
      wstrb <= 4'hf;
      rd_chk(ad_np, 16'h1aff);
   endtask : t_nptx

   // ----------------------------------------------------------------
   // Run
   // ----------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset();
      t_pages();
      t_flags();
      t_alt();
      t_nptx();
      final_report();
   end

   // About 160 cycles are needed; a hang ends here
   initial
   begin
      repeat (5000) @(posedge aclk);
      n_mismatch++;
      final_report();
   end
endmodule : tb

`default_nettype wire
